// file: include/ild_pkg.sv
// Shared constants and carrier types for the injector low-side driver block.
// Assumes a single 50 MHz clock and a 32-bit AHB-Lite register port.
package ild_pkg;

  // ==========================================================================
  // Timing
  localparam int NCH = 5;
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_CYC = CLK_HZ / 1_000_000;
  localparam int OVC_FILT_US = 3;
  localparam int OVC_FILT_MIN_US = 2;
  localparam int OVC_FILT_MAX_US = 4;
  localparam int DIAG_FILT_US = 50;
  localparam int DIAG_FILT_MIN_US = 35;
  localparam int DIAG_FILT_MAX_US = 65;
  localparam int MASK_MIN_US = 300;
  localparam int MASK_MAX_US = 500;
  localparam int OVC_MIN_CYC = OVC_FILT_MIN_US * TICK_CYC;
  localparam int OVC_MAX_CYC = OVC_FILT_MAX_US * TICK_CYC;
  localparam int DIAG_MIN_CYC = DIAG_FILT_MIN_US * TICK_CYC;
  localparam int MASK_MIN_CYC = MASK_MIN_US * TICK_CYC;

  // ==========================================================================
  // Register map
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_STATE = 8'h0C;
  localparam int CTRL_ON_LSB = 0;
  localparam int CTRL_DIS_BIT = 8;
  localparam int EVT_OVC_LSB = 0;
  localparam int EVT_OPEN_LSB = 8;
  localparam int EVT_STG_LSB = 16;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam logic [2:0] SIZE_WORD = 3'h2;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [NCH-1:0] stg;
    logic [NCH-1:0] open;
    logic [NCH-1:0] ovc;
  } ild_evt_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic word;
    logic [7:0] addr;
  } ild_aph_t;

endpackage

// file: logic/ild_tick.sv
// Microsecond tick divider: one-cycle enable every DIV clocks.
// Assumes a free-running clock and an asynchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module ild_tick
  import ild_pkg::*;
#(
  parameter int DIV = TICK_CYC
)
(
  input wire logic clk,
  input wire logic nrst,
  output logic tick
);
  logic [7:0] cnt;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt <= 8'h00;
      tick <= 1'b0;
    end
    else if (cnt == 8'(DIV - 1))
    begin
      cnt <= 8'h00;
      tick <= 1'b1;
    end
    else
    begin
      cnt <= cnt + 8'h01;
      tick <= 1'b0;
    end
  end
endmodule // ild_tick
`default_nettype wire

// file: logic/ild_filt.sv
// Persistence filter: done rises once cond has held for N ticks.
// Assumes tick is a one-cycle enable; any drop of cond restarts the count.
`timescale 1ns/1ns
`default_nettype none
module ild_filt
#(
  parameter int N = 3,
  parameter int W = 10
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic tick,
  input wire logic cond,
  output logic done
);
  logic [W-1:0] cnt;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cnt <= '0;
    else if (!cond)
      cnt <= '0;
    else if (tick && cnt != W'(N))
      cnt <= cnt + 1'b1;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      done <= 1'b0;
    else
      done <= cond && cnt == W'(N);
  end
endmodule // ild_filt
`default_nettype wire

// file: logic/ild_ctrl.sv
// Control and protection for five injector low-side driver channels.
// Assumes comparator and parallel inputs already synchronous to CLOCK,
// and a single-master AHB-Lite bus with whole-word transfers.
//
// How it works
// - Five channels each carry their own overcurrent and diagnosis logic.
// - A channel is on only when its control bit and parallel input are high.
// - Chip reset or the global output disable forces every channel off.
// - A confirmed overcurrent turns the channel off by the fast path.
// - Overcurrent is confirmed only after persisting 2 to 4 us.
// - Off-state open or short faults need 35 to 65 us of persistence.
// - Off-state diagnosis is ignored for 300 to 500 us after switch-off.
//
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
module ild_ctrl
  import ild_pkg::*;
#(
  parameter int MASK_US = MASK_MIN_US
)
(
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic CHIP_RESET,
  input wire logic [NCH-1:0] PAR_IN,
  input wire logic [NCH-1:0] OVC_CMP,
  input wire logic [NCH-1:0] CMP_LO,
  input wire logic [NCH-1:0] CMP_HI,
  output logic [NCH-1:0] DRV_ON,
  output logic [NCH-1:0] FAST_OFF,
  output logic IRQ
);
  // ==========================================================================
  // Declarations
  ild_aph_t aph;
  ild_evt_t evt;
  ild_evt_t stat;
  ild_evt_t mask;
  logic [NCH-1:0] ctrl_on;
  logic ctrl_dis;
  logic tick;
  logic [NCH-1:0] cmd_on;
  logic [NCH-1:0] ovc_done;
  logic [NCH-1:0] ovc_prev;
  logic [NCH-1:0] diag_arm;
  logic [NCH-1:0] open_done;
  logic [NCH-1:0] open_prev;
  logic [NCH-1:0] stg_done;
  logic [NCH-1:0] stg_prev;
  logic wr_ok;
  logic [31:0] w1c;

  ild_tick #(
    .DIV(TICK_CYC)
  ) u_tick (
    .clk(CLOCK),
    .nrst(NRST),
    .tick(tick)
  );

  // ==========================================================================
  // Per-channel drive and diagnosis
  // one identical slice per channel
  genvar i;
  generate
    for (i = 0; i < NCH; i++)
    begin : g_ch
      logic [15:0] ovc_run;
      logic [15:0] off_run;
      logic [15:0] open_run;
      logic [15:0] stg_run;

      // AND of control bit and input, overridden by disables
      assign cmd_on[i] = ctrl_on[i] & PAR_IN[i] & ~ctrl_dis & ~CHIP_RESET;

      // overcurrent persistence, counted only while driving
      ild_filt #(
        .N(OVC_FILT_US),
        .W(4)
      ) u_ovc (
        .clk(CLOCK),
        .nrst(NRST),
        .tick(tick),
        .cond(DRV_ON[i] & OVC_CMP[i]),
        .done(ovc_done[i])
      );

      // latch stays until the command drops, so no retry into a short
      always_ff @(posedge CLOCK or negedge NRST)
      begin
        if (!NRST)
          FAST_OFF[i] <= 1'b0;
        else if (ovc_done[i])
          FAST_OFF[i] <= 1'b1;
        else if (!cmd_on[i])
          FAST_OFF[i] <= 1'b0;
      end

      always_ff @(posedge CLOCK or negedge NRST)
      begin
        if (!NRST)
          DRV_ON[i] <= 1'b0;
        else
          DRV_ON[i] <= cmd_on[i] & ~FAST_OFF[i] & ~ovc_done[i];
      end

      // mask one tick past the minimum so edge jitter cannot shorten it
      ild_filt #(
        .N(MASK_US + 1),
        .W(10)
      ) u_mask (
        .clk(CLOCK),
        .nrst(NRST),
        .tick(tick),
        .cond(~DRV_ON[i]),
        .done(diag_arm[i])
      );

      // short to ground: below the low threshold
      ild_filt #(
        .N(DIAG_FILT_US),
        .W(7)
      ) u_stg (
        .clk(CLOCK),
        .nrst(NRST),
        .tick(tick),
        .cond(diag_arm[i] & ~DRV_ON[i] & ~CMP_LO[i]),
        .done(stg_done[i])
      );

      // open load: between the two thresholds
      ild_filt #(
        .N(DIAG_FILT_US),
        .W(7)
      ) u_open (
        .clk(CLOCK),
        .nrst(NRST),
        .tick(tick),
        .cond(diag_arm[i] & ~DRV_ON[i] & CMP_LO[i] & ~CMP_HI[i]),
        .done(open_done[i])
      );

      always_ff @(posedge CLOCK or negedge NRST)
      begin
        if (!NRST)
        begin
          ovc_prev[i] <= 1'b0;
          open_prev[i] <= 1'b0;
          stg_prev[i] <= 1'b0;
        end
        else
        begin
          ovc_prev[i] <= ovc_done[i];
          open_prev[i] <= open_done[i];
          stg_prev[i] <= stg_done[i];
        end
      end

      assign evt.ovc[i] = ovc_done[i] & ~ovc_prev[i];
      assign evt.open[i] = open_done[i] & ~open_prev[i];
      assign evt.stg[i] = stg_done[i] & ~stg_prev[i];

      // Run-length counters read only by the checks below
      always_ff @(posedge CLOCK or negedge NRST)
      begin
        if (!NRST)
        begin
          ovc_run <= 16'h0000;
          off_run <= 16'h0000;
          open_run <= 16'h0000;
          stg_run <= 16'h0000;
        end
        else
        begin
          ovc_run <= (DRV_ON[i] & OVC_CMP[i]) ?
                     ovc_run + 16'h0001 : 16'h0000;
          off_run <= DRV_ON[i] ? 16'h0000 :
                     (&off_run) ? off_run : off_run + 16'h0001;
          open_run <= (CMP_LO[i] & ~CMP_HI[i] & ~DRV_ON[i]) ?
                      open_run + 16'h0001 : 16'h0000;
          stg_run <= (~CMP_LO[i] & ~DRV_ON[i]) ?
                     stg_run + 16'h0001 : 16'h0000;
        end
      end

      ovc_fast_a: assert property (@(posedge CLOCK)
        disable iff (!NRST) $rose(ovc_done[i]) |=> !DRV_ON[i] && FAST_OFF[i])
        else $error("overcurrent did not force fast switch-off");
      ovc_filt_a: assert property (@(posedge CLOCK)
        disable iff (!NRST) $rose(ovc_done[i]) |-> ovc_run > 16'(OVC_MIN_CYC))
        else $error("overcurrent confirmed too early");
      ovc_max_a: assert property (@(posedge CLOCK)
        disable iff (!NRST) ovc_run <= 16'(OVC_MAX_CYC))
        else $error("overcurrent not confirmed in time");
      open_filt_a: assert property (@(posedge CLOCK)
        disable iff (!NRST) $rose(open_done[i]) |->
          open_run > 16'(DIAG_MIN_CYC) && $past(CMP_LO[i] && !CMP_HI[i]))
        else $error("open load reported too early");
      stg_class_a: assert property (@(posedge CLOCK)
        disable iff (!NRST) $rose(stg_done[i]) |->
          stg_run > 16'(DIAG_MIN_CYC) && $past(!CMP_LO[i]))
        else $error("short to ground misreported");
      // Held against the mask this instance is built with
      diag_mask_a: assert property (@(posedge CLOCK)
        disable iff (!NRST) diag_arm[i] |-> off_run >= 16'(MASK_US*TICK_CYC))
        else $error("diagnosis armed inside mask time");
    end
  endgenerate

  drv_and_a: assert property (@(posedge CLOCK)
    disable iff (!NRST) (DRV_ON & ~$past(ctrl_on & PAR_IN)) == '0)
    else $error("driver on without control bit and input");
  force_off_a: assert property (@(posedge CLOCK)
    disable iff (!NRST) (ctrl_dis || CHIP_RESET) |=> DRV_ON == '0)
    else $error("driver on during disable or chip reset");

  // ==========================================================================
  // AHB-Lite slave: zero wait states, read data latched in address phase
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      aph <= '0;
    else if (HREADY)
    begin
      aph.valid <= HSEL & HTRANS[1];
      aph.write <= HWRITE;
      aph.word <= (HSIZE == SIZE_WORD) && (HADDR[31:8] == 24'h00_0000);
      aph.addr <= HADDR[7:0];
    end
  end

  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
    else
    begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

  // Reads take the value at the address phase; a read right behind a
  // write to the same register returns the old contents
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      HRDATA <= 32'h0000_0000;
    else if (HREADY && HSEL && HTRANS[1] && !HWRITE
             && HADDR[31:8] == 24'h00_0000)
    begin
      if (HADDR[7:0] == OFS_CTRL)
        HRDATA <= {23'h00_0000, ctrl_dis, 3'h0, ctrl_on};
      else if (HADDR[7:0] == OFS_STAT)
        HRDATA <= {11'h000, stat.stg, 3'h0, stat.open, 3'h0, stat.ovc};
      else if (HADDR[7:0] == OFS_MASK)
        HRDATA <= {11'h000, mask.stg, 3'h0, mask.open, 3'h0, mask.ovc};
      else if (HADDR[7:0] == OFS_STATE)
        HRDATA <= {11'h000, diag_arm, 3'h0, FAST_OFF, 3'h0, DRV_ON};
      else
        HRDATA <= 32'h0000_0000;
    end
    else
      HRDATA <= 32'h0000_0000;
  end

  assign wr_ok = aph.valid & aph.write & aph.word;

  // ==========================================================================
  // Control, mask and sticky status
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      ctrl_on <= CTRL_RST[CTRL_ON_LSB +: NCH];
      ctrl_dis <= CTRL_RST[CTRL_DIS_BIT];
    end
    else if (wr_ok && aph.addr == OFS_CTRL)
    begin
      ctrl_on <= HWDATA[CTRL_ON_LSB +: NCH];
      ctrl_dis <= HWDATA[CTRL_DIS_BIT];
    end
  end

  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
    begin
      mask.ovc <= MASK_RST[EVT_OVC_LSB +: NCH];
      mask.open <= MASK_RST[EVT_OPEN_LSB +: NCH];
      mask.stg <= MASK_RST[EVT_STG_LSB +: NCH];
    end
    else if (wr_ok && aph.addr == OFS_MASK)
    begin
      mask.ovc <= HWDATA[EVT_OVC_LSB +: NCH];
      mask.open <= HWDATA[EVT_OPEN_LSB +: NCH];
      mask.stg <= HWDATA[EVT_STG_LSB +: NCH];
    end
  end

  assign w1c = (wr_ok && aph.addr == OFS_STAT) ? HWDATA : 32'h0000_0000;

  // A fresh event beats a clear in the same cycle
  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      stat <= '0;
    else
    begin
      stat.ovc <= (stat.ovc & ~w1c[EVT_OVC_LSB +: NCH]) | evt.ovc;
      stat.open <= (stat.open & ~w1c[EVT_OPEN_LSB +: NCH]) | evt.open;
      stat.stg <= (stat.stg & ~w1c[EVT_STG_LSB +: NCH]) | evt.stg;
    end
  end

  always_ff @(posedge CLOCK or negedge NRST)
  begin
    if (!NRST)
      IRQ <= 1'b0;
    else
      IRQ <= |(stat & mask);
  end

  irq_level_a: assert property (@(posedge CLOCK)
    disable iff (!NRST) $rose(stat.ovc[0]) && mask.ovc[0] |=> IRQ)
    else $error("unmasked overcurrent raised no interrupt");

endmodule // ild_ctrl
`default_nettype wire

// file: test/ild_mcu.sv
// Far-side model: microcontroller pins plus load faults on the outputs.
// Assumes one clock; faults are set by the bench through task set_io.
`timescale 1ns/1ns
`default_nettype none
module ild_mcu
  import ild_pkg::*;
(
  input wire logic clk,
  input wire logic [NCH-1:0] drv_on,
  output logic [NCH-1:0] par_in,
  output logic [NCH-1:0] ovc_cmp,
  output logic [NCH-1:0] cmp_lo,
  output logic [NCH-1:0] cmp_hi
);
  logic [NCH-1:0] bat;
  logic [NCH-1:0] gnd;
  logic [NCH-1:0] opn;

  initial
  begin
    par_in = '0;
    ovc_cmp = '0;
    cmp_lo = '1;
    cmp_hi = '1;
    bat = '0;
    gnd = '0;
    opn = '0;
  end

  task automatic set_io(input logic [NCH-1:0] p, b, g, o);
    @(posedge clk);
    par_in <= p;
    bat <= b;
    gnd <= g;
    opn <= o;
  endtask

  // ==========================================================================
  // Load model
  // A short to battery only draws current while the switch conducts
  always @(posedge clk)
  begin
    ovc_cmp <= bat & drv_on;
    cmp_lo <= ~gnd;
    cmp_hi <= ~gnd & ~opn;
  end
endmodule // ild_mcu
`default_nettype wire

// file: test/ild_ctrl_bench.sv
// Self-checking bench for the injector driver control block.
// Assumes AHB-Lite single slave with HREADY looped from HREADYOUT.
`timescale 1ns/1ns
`default_nettype none
module ild_ctrl_bench
  import ild_pkg::*;
;
  logic CLOCK = 0;
  logic NRST = 0;
  logic HSEL = 0;
  logic [31:0] HADDR = '0;
  logic [1:0] HTRANS = '0;
  logic HWRITE = 0;
  logic [2:0] HSIZE = '0;
  logic [31:0] HWDATA = '0;
  logic CHIP_RESET = 0;
  logic [31:0] HRDATA;
  logic HREADYOUT;
  logic HRESP;
  logic [NCH-1:0] PAR_IN, OVC_CMP, CMP_LO, CMP_HI, DRV_ON, FAST_OFF;
  logic IRQ;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  int ctrl, par, n, i;
  logic [31:0] rd;

  always #10 CLOCK = ~CLOCK;

  ild_ctrl #(.MASK_US(3)) u_dut (.CLOCK(CLOCK), .NRST(NRST), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
    .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CHIP_RESET(CHIP_RESET),
    .PAR_IN(PAR_IN), .OVC_CMP(OVC_CMP), .CMP_LO(CMP_LO), .CMP_HI(CMP_HI),
    .DRV_ON(DRV_ON), .FAST_OFF(FAST_OFF), .IRQ(IRQ));

  ild_mcu u_mcu (.clk(CLOCK), .drv_on(DRV_ON), .par_in(PAR_IN),
    .ovc_cmp(OVC_CMP), .cmp_lo(CMP_LO), .cmp_hi(CMP_HI));

  // ==========================================================================
  // Helpers
  task automatic results();
    $display("checks %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Bus cycle: address phase held until ready, then data phase
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge CLOCK);
    HSEL <= 1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= a;
    HSIZE <= SIZE_WORD;
    do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
    HSEL <= 0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
  endtask

  task automatic wait_cyc(input int k);
    repeat (k) @(posedge CLOCK);
  endtask

  // Sized for the shortened mask and the 50 us filter
  always @(posedge CLOCK)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_total++;
      results();
    end
  end

  // ==========================================================================
  // Main sequence
  initial
  begin
    void'($urandom(54626));
    wait_cyc(10);
    NRST <= 1;
    bus(0, {24'h0, OFS_CTRL}, 0);
    chk(rd, CTRL_RST);
    chk({31'h0, HRESP}, 0);
    bus(0, {24'h0, OFS_MASK}, 0);
    chk(rd, MASK_RST);
    bus(0, {24'h0, OFS_STAT}, 0);
    chk(rd, 32'h0000_0000);
    bus(0, 32'h0000_0040, 0);
    chk(rd, 32'h0000_0000);
    for (i = 0; i < 8; i++)
    begin
      ctrl = $urandom & 32'h0000_011F;
      par = $urandom & 32'h0000_001F;
      bus(1, {24'h0, OFS_CTRL}, ctrl);
      u_mcu.set_io(par[4:0], '0, '0, '0);
      wait_cyc(3);
      n = ctrl[8] ? 0 : ctrl & par & 32'h1F;
      chk({27'h0, DRV_ON}, n);
      bus(0, {24'h0, OFS_STATE}, 0);
      chk(rd & 32'h1F, n);
    end
    bus(1, {24'h0, OFS_CTRL}, 32'h0000_001F);
    u_mcu.set_io(5'h1F, '0, '0, '0);
    wait_cyc(3);
    chk({27'h0, DRV_ON}, 32'h1F);
    CHIP_RESET <= 1;
    wait_cyc(3);
    chk({27'h0, DRV_ON}, 0);
    CHIP_RESET <= 0;
    // Mask is set before the fault so the interrupt path sees a fresh event
    bus(1, {24'h0, OFS_MASK}, 32'h0000_0001);
    chk(IRQ, 0);
    u_mcu.set_io(5'h1F, 5'h01, '0, '0);
    n = 0;
    while (FAST_OFF[0] !== 1'b1 && n < 400)
    begin
      @(posedge CLOCK);
      n++;
    end
    chk(n >= 100 && n <= 160, 1);
    chk({27'h0, DRV_ON}, 32'h1E);
    wait_cyc(2);
    chk(IRQ, 1);
    bus(0, {24'h0, OFS_STAT}, 0);
    chk(rd, 32'h0000_0001);
    bus(1, {24'h0, OFS_STAT}, 32'h0000_0001);
    wait_cyc(2);
    chk(IRQ, 0);
    u_mcu.set_io(5'h1E, '0, '0, '0);
    wait_cyc(3);
    chk({27'h0, FAST_OFF}, 0);
    bus(1, {24'h0, OFS_CTRL}, 32'h0000_0000);
    wait_cyc(400);
    bus(1, {24'h0, OFS_STAT}, 32'hFFFF_FFFF);
    u_mcu.set_io('0, '0, 5'h02, 5'h04);
    wait_cyc(1700);
    bus(0, {24'h0, OFS_STAT}, 0);
    chk(rd, 0);
    wait_cyc(900);
    bus(0, {24'h0, OFS_STAT}, 0);
    chk(rd, 32'h0002_0400);
    bus(1, {24'h0, OFS_MASK}, 32'h001F_1F1F);
    wait_cyc(2);
    chk(IRQ, 1);
    // Mid-run reset must clear status, mask and the interrupt
    @(posedge CLOCK);
    NRST <= 0;
    wait_cyc(2);
    chk(IRQ, 0);
    NRST <= 1;
    bus(0, {24'h0, OFS_STAT}, 0);
    chk(rd, 0);
    bus(0, {24'h0, OFS_MASK}, 0);
    chk(rd, MASK_RST);
    results();
  end
endmodule // ild_ctrl_bench
`default_nettype wire
